//--- src/lcsc_consts.svh
// constants for the laser current sweep control block
`ifndef LCSC_CONSTS_SVH
`define LCSC_CONSTS_SVH

// =====================================================
// clock and timing
`define LCSC_CLK_KHZ 40000
`define LCSC_ENA_DELAY_MS 2000
`define LCSC_HOLDOFF_MS 3000
`define LCSC_TRIG_DELAY_US 10000
`define LCSC_TRIG_WIDTH_US 20
`define LCSC_TRIG_WIDTH_CYC (`LCSC_TRIG_WIDTH_US * `LCSC_CLK_KHZ / 1000)
`define LCSC_MIN_INTERVAL_MS 16'h0064
`define LCSC_ADVISE_INTERVAL_MS 16'h07d0

// =====================================================
// current scale: full scale is 10000 counts
`define LCSC_STEP_MIN 16'h0064
`define LCSC_STEP_MAX 16'h03e8
`define LCSC_REC_MAX 7'h63

// =====================================================
// settings word positions
`define LCSC_NSET 10
`define LCSC_S_SETPOINT 4'h0
`define LCSC_S_LIMIT 4'h1
`define LCSC_S_VMAX 4'h2
`define LCSC_S_CABLE 4'h3
`define LCSC_S_BRIGHT 4'h4
`define LCSC_S_BEEP 4'h5
`define LCSC_S_START 4'h6
`define LCSC_S_STOP 4'h7
`define LCSC_S_STEP 4'h8
`define LCSC_S_INTERVAL 4'h9

// =====================================================
// factory defaults
`define LCSC_DEF_SETPOINT 16'h0000
`define LCSC_DEF_LIMIT 16'h2710
`define LCSC_DEF_VMAX 16'h0fa0
`define LCSC_DEF_CABLE 16'h0000
`define LCSC_DEF_BRIGHT 16'h0064
`define LCSC_DEF_BEEP 16'h0001
`define LCSC_DEF_START 16'h0000
`define LCSC_DEF_STOP 16'h2710
`define LCSC_DEF_STEP 16'h03e8
`define LCSC_DEF_INTERVAL 16'h07d0

`endif

//--- src/lcsc_pkg.sv
// types of the laser current sweep control block
package lcsc_pkg;
  typedef enum logic [1:0] {ENA_OFF = 2'b00, ENA_WAIT = 2'b01, ENA_ON = 2'b10} lcsc_ena_t;
  typedef enum logic [1:0] {LK_NONE = 2'b00, LK_LOCAL = 2'b01, LK_PASSWORD = 2'b10} lcsc_lock_t;
  typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_SETTLE = 2'b01, SW_MEAS = 2'b10} lcsc_sweep_t;
  typedef enum logic [1:0] {CP_IDLE = 2'b00, CP_SAVE = 2'b01, CP_RECALL = 2'b10} lcsc_copy_t;
  typedef enum logic [1:0] {TG_IDLE = 2'b00, TG_DELAY = 2'b01, TG_PULSE = 2'b10} lcsc_trig_t;
endpackage

//--- src/lcsc_prof_mem.sv
// profile store: four slots of sixteen setting words, registered read
`timescale 1ns/1ps
`default_nettype none
module lcsc_prof_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [64];
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = mem[addr];
  end

  // array has no reset: contents are undefined until a slot is saved
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_next;
    end
  end
endmodule // lcsc_prof_mem
`default_nettype wire

//--- src/lcsc_top.sv
// laser current sweep control: enable gating, sweep, profiles, lock, trigger
// How it works
// - enable waits fixed delay, current and indicator together
// - indicator lit only while current delivered
// - step size between one and ten percent
// - reject short settling interval, advise two seconds
// - sweep from start, settle, measure, advance step
// - final reading exactly at stop, never beyond
// - each step timed from previous step end
// - stop ends sweep, collected readings still kept
// - sweep completion disables output, zeroes setpoint
// - records numbered from zero, two digits
// - profile save and recall of ten settings
// - factory recall restores all defaults
// - modulation adds to setpoint, clamped at limit
// - start unlocked; lock blocks knob for setpoint, limit, vmax, cable; password remote-only
// - enable status low while output enabled
// - remote setpoint change gives delayed fixed pulse
// - key switch locked disables output current
// - power back on within holdoff is refused
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_consts.svh"
module lcsc_top #(
  parameter int MS_CYC = `LCSC_CLK_KHZ,
  parameter int ENA_CYC = `LCSC_ENA_DELAY_MS * `LCSC_CLK_KHZ,
  parameter int HOLD_CYC = `LCSC_HOLDOFF_MS * `LCSC_CLK_KHZ,
  parameter int TRIG_DLY_CYC = `LCSC_TRIG_DELAY_US * `LCSC_CLK_KHZ / 1000
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic FRONT_POWER,
  input wire logic KEY_UNLOCKED,
  input wire logic ENABLE_REQ,
  input wire logic DISABLE_REQ,
  input wire logic [3:0] SET_SEL,
  input wire logic [15:0] SET_DATA,
  input wire logic SET_KNOB_WR,
  input wire logic SET_REMOTE_WR,
  input wire logic LOCK_LOCAL_REQ,
  input wire logic UNLOCK_LOCAL_REQ,
  input wire logic LOCK_REMOTE_REQ,
  input wire logic LOCK_REMOTE_PW,
  input wire logic UNLOCK_REMOTE_REQ,
  input wire logic signed [15:0] ANALOG_MODULATION_INPUT,
  input wire logic RUN_REQ,
  input wire logic STOP_REQ,
  input wire logic [1:0] PROF_SLOT,
  input wire logic SAVE_REQ,
  input wire logic RECALL_REQ,
  input wire logic FACTORY_REQ,
  input wire logic [15:0] MEAS_VOLTAGE,
  output logic APP_POWER,
  output logic OUT_EN,
  output logic [15:0] OUT_CURRENT,
  output logic ENABLE_LED,
  output logic ENABLE_STATUS_N,
  output logic TRIGGER,
  output lcsc_pkg::lcsc_lock_t LOCK_STATE,
  output logic SWEEP_BUSY,
  output logic SWEEP_REJECT,
  output logic INTERVAL_ADVISE,
  output logic READ_VALID,
  output logic [15:0] READ_CURRENT,
  output logic [15:0] READ_VOLTAGE,
  output logic RECORD_DONE,
  output logic [6:0] RECORD_INDEX
);
  import lcsc_pkg::*;

  function automatic logic is_critical(input logic [3:0] sel);
    is_critical = (sel <= `LCSC_S_CABLE);
  endfunction

  function automatic logic [15:0] factory_val(input int i);
    logic [15:0] v [`LCSC_NSET];
    v = '{`LCSC_DEF_SETPOINT, `LCSC_DEF_LIMIT, `LCSC_DEF_VMAX, `LCSC_DEF_CABLE, `LCSC_DEF_BRIGHT,
          `LCSC_DEF_BEEP, `LCSC_DEF_START, `LCSC_DEF_STOP, `LCSC_DEF_STEP, `LCSC_DEF_INTERVAL};
    factory_val = v[i];
  endfunction

  // =====================================================
  // power holdoff and output enable
  logic pw_prev_reg, app_reg, on_reg;
  logic app_next, on_next;
  logic [26:0] hold_cnt_reg, hold_cnt_next, ena_cnt_reg, ena_cnt_next;
  lcsc_ena_t ena_st_reg, ena_st_next;
  logic sw_finish;

  always_comb begin
    app_next = app_reg;
    hold_cnt_next = hold_cnt_reg;
    if (hold_cnt_reg != 27'h0) begin
      hold_cnt_next = hold_cnt_reg - 27'h1;
    end
    if (pw_prev_reg && !FRONT_POWER && app_reg) begin
      app_next = 1'b0;
      hold_cnt_next = 27'(HOLD_CYC - 1);
    end else if (!pw_prev_reg && FRONT_POWER && hold_cnt_reg == 27'h0) begin
      app_next = 1'b1;
    end
    ena_st_next = ena_st_reg;
    ena_cnt_next = ena_cnt_reg;
    case (ena_st_reg)
      ENA_OFF: begin
        if (ENABLE_REQ && KEY_UNLOCKED && app_reg) begin
          ena_st_next = ENA_WAIT;
          ena_cnt_next = 27'h0;
        end
      end
      ENA_WAIT: begin
        if (ena_cnt_reg == 27'(ENA_CYC - 1)) begin
          ena_st_next = ENA_ON;
        end else begin
          ena_cnt_next = ena_cnt_reg + 27'h1;
        end
      end
      ENA_ON: ena_st_next = ENA_ON;
      default: ena_st_next = ENA_OFF;
    endcase
    if (!KEY_UNLOCKED || !app_reg || DISABLE_REQ || sw_finish) begin
      ena_st_next = ENA_OFF;
    end
    on_next = (ena_st_next == ENA_ON);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pw_prev_reg <= 1'b0;
      app_reg <= 1'b0;
      hold_cnt_reg <= 27'h0;
      ena_st_reg <= ENA_OFF;
      ena_cnt_reg <= 27'h0;
      on_reg <= 1'b0;
    end else begin
      pw_prev_reg <= FRONT_POWER;
      app_reg <= app_next;
      hold_cnt_reg <= hold_cnt_next;
      ena_st_reg <= ena_st_next;
      ena_cnt_reg <= ena_cnt_next;
      on_reg <= on_next;
    end
  end

  // =====================================================
  // trigger after remote setpoint change
  lcsc_trig_t tg_st_reg, tg_st_next;
  logic [18:0] tg_cnt_reg, tg_cnt_next;
  logic remote_sp;

  always_comb begin
    remote_sp = SET_REMOTE_WR && SET_SEL == `LCSC_S_SETPOINT;
    tg_st_next = tg_st_reg;
    tg_cnt_next = tg_cnt_reg + 19'h1;
    case (tg_st_reg)
      TG_IDLE: tg_cnt_next = 19'h0;
      TG_DELAY: begin
        if (tg_cnt_reg == 19'(TRIG_DLY_CYC - 1)) begin
          tg_st_next = TG_PULSE;
          tg_cnt_next = 19'h0;
        end
      end
      TG_PULSE: begin
        if (tg_cnt_reg == 19'(`LCSC_TRIG_WIDTH_CYC - 1)) begin
          tg_st_next = TG_IDLE;
        end
      end
      default: tg_st_next = TG_IDLE;
    endcase
    // a later change restarts the delay; a pulse in flight is cut short
    if (remote_sp) begin
      tg_st_next = TG_DELAY;
      tg_cnt_next = 19'h0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tg_st_reg <= TG_IDLE;
      tg_cnt_reg <= 19'h0;
      TRIGGER <= 1'b0;
    end else begin
      tg_st_reg <= tg_st_next;
      tg_cnt_reg <= tg_cnt_next;
      TRIGGER <= (tg_st_next == TG_PULSE);
    end
  end

  // =====================================================
  // sweep sequencer
  lcsc_sweep_t sw_st_reg, sw_st_next;
  logic [15:0] level_reg, level_next, ms_reg, ms_next;
  logic [15:0] div_reg, div_next;
  logic [6:0] rec_idx_next;
  logic [16:0] step_sum;
  logic sw_write, reject_next, rd_next, done_next;
  logic [15:0] set_reg [`LCSC_NSET];
  lcsc_copy_t cp_st_reg;

  always_comb begin
    sw_st_next = sw_st_reg;
    level_next = level_reg;
    ms_next = ms_reg;
    div_next = div_reg + 16'h1;
    rec_idx_next = RECORD_INDEX;
    sw_write = 1'b0;
    sw_finish = 1'b0;
    reject_next = 1'b0;
    rd_next = 1'b0;
    done_next = 1'b0;
    step_sum = {1'b0, level_reg} + {1'b0, set_reg[`LCSC_S_STEP]};
    case (sw_st_reg)
      SW_IDLE: begin
        if (RUN_REQ && on_reg && cp_st_reg == CP_IDLE) begin
          if (set_reg[`LCSC_S_STEP] < `LCSC_STEP_MIN || set_reg[`LCSC_S_STEP] > `LCSC_STEP_MAX ||
              set_reg[`LCSC_S_INTERVAL] < `LCSC_MIN_INTERVAL_MS ||
              set_reg[`LCSC_S_START] > set_reg[`LCSC_S_STOP]) begin
            reject_next = 1'b1;
          end else begin
            sw_st_next = SW_SETTLE;
            level_next = set_reg[`LCSC_S_START];
            sw_write = 1'b1;
            div_next = 16'h0;
            ms_next = 16'h0;
          end
        end
      end
      SW_SETTLE: begin
        if (div_reg == 16'(MS_CYC - 1)) begin
          div_next = 16'h0;
          ms_next = ms_reg + 16'h1;
          if (ms_reg + 16'h1 >= set_reg[`LCSC_S_INTERVAL]) begin
            sw_st_next = SW_MEAS;
          end
        end
      end
      SW_MEAS: begin
        rd_next = 1'b1;
        if (level_reg >= set_reg[`LCSC_S_STOP]) begin
          sw_st_next = SW_IDLE;
          sw_finish = 1'b1;
          done_next = 1'b1;
        end else begin
          level_next = (step_sum > {1'b0, set_reg[`LCSC_S_STOP]}) ? set_reg[`LCSC_S_STOP] : step_sum[15:0];
          sw_write = 1'b1;
          sw_st_next = SW_SETTLE;
          div_next = 16'h0;
          ms_next = 16'h0;
        end
      end
      default: sw_st_next = SW_IDLE;
    endcase
    if (STOP_REQ && sw_st_reg != SW_IDLE) begin
      sw_st_next = SW_IDLE;
      sw_write = 1'b0;
      done_next = 1'b1;
    end
    if (done_next) begin
      rec_idx_next = (RECORD_INDEX == `LCSC_REC_MAX) ? 7'h00 : RECORD_INDEX + 7'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sw_st_reg <= SW_IDLE;
      level_reg <= 16'h0000;
      ms_reg <= 16'h0000;
      div_reg <= 16'h0000;
      SWEEP_BUSY <= 1'b0;
      SWEEP_REJECT <= 1'b0;
      READ_VALID <= 1'b0;
      READ_CURRENT <= 16'h0000;
      READ_VOLTAGE <= 16'h0000;
      RECORD_DONE <= 1'b0;
      RECORD_INDEX <= 7'h00;
    end else begin
      sw_st_reg <= sw_st_next;
      level_reg <= level_next;
      ms_reg <= ms_next;
      div_reg <= div_next;
      SWEEP_BUSY <= (sw_st_next != SW_IDLE);
      SWEEP_REJECT <= reject_next;
      READ_VALID <= rd_next;
      READ_CURRENT <= rd_next ? level_reg : READ_CURRENT;
      READ_VOLTAGE <= rd_next ? MEAS_VOLTAGE : READ_VOLTAGE;
      RECORD_DONE <= done_next;
      RECORD_INDEX <= rec_idx_next;
    end
  end

  // =====================================================
  // settings, lock and profile copy
  logic [15:0] set_next [`LCSC_NSET];
  lcsc_lock_t lock_next;
  lcsc_copy_t cp_st_next;
  logic [3:0] cp_cnt_reg, cp_cnt_next;
  logic [1:0] slot_reg, slot_next;
  logic mem_we;
  logic [15:0] mem_rdata;
  logic [17:0] mod_sum;
  logic [15:0] cur_next;

  always_comb begin
    set_next = set_reg;
    lock_next = LOCK_STATE;
    if (LOCK_LOCAL_REQ && LOCK_STATE == LK_NONE) begin
      lock_next = LK_LOCAL;
    end else if (UNLOCK_LOCAL_REQ && LOCK_STATE == LK_LOCAL) begin
      lock_next = LK_NONE;
    end
    if (LOCK_REMOTE_REQ) begin
      lock_next = LOCK_REMOTE_PW ? LK_PASSWORD : LK_LOCAL;
    end else if (UNLOCK_REMOTE_REQ) begin
      lock_next = LK_NONE;
    end
    if (SET_REMOTE_WR && SET_SEL < 4'(`LCSC_NSET)) begin
      set_next[SET_SEL] = SET_DATA;
    end else if (SET_KNOB_WR && SET_SEL < 4'(`LCSC_NSET) && !(LOCK_STATE != LK_NONE && is_critical(SET_SEL))) begin
      set_next[SET_SEL] = SET_DATA;
    end
    cp_st_next = cp_st_reg;
    cp_cnt_next = cp_cnt_reg + 4'h1;
    slot_next = slot_reg;
    mem_we = 1'b0;
    case (cp_st_reg)
      CP_IDLE: begin
        cp_cnt_next = 4'h0;
        if (sw_st_reg == SW_IDLE) begin
          slot_next = PROF_SLOT;
          if (SAVE_REQ) begin
            cp_st_next = CP_SAVE;
          end else if (RECALL_REQ) begin
            cp_st_next = CP_RECALL;
          end else if (FACTORY_REQ) begin
            for (int i = 0; i < `LCSC_NSET; i++) begin
              set_next[i] = factory_val(i);
            end
          end
        end
      end
      CP_SAVE: begin
        mem_we = 1'b1;
        if (cp_cnt_reg == 4'(`LCSC_NSET - 1)) begin
          cp_st_next = CP_IDLE;
        end
      end
      CP_RECALL: begin
        if (cp_cnt_reg != 4'h0) begin
          set_next[cp_cnt_reg - 4'h1] = mem_rdata;
        end
        if (cp_cnt_reg == 4'(`LCSC_NSET)) begin
          cp_st_next = CP_IDLE;
        end
      end
      default: cp_st_next = CP_IDLE;
    endcase
    if (sw_write) begin
      set_next[`LCSC_S_SETPOINT] = level_next;
    end
    if (sw_finish) begin
      set_next[`LCSC_S_SETPOINT] = 16'h0000;
    end
    // signed sum, floored at zero and clamped at the limit without dropping enable
    mod_sum = {2'b00, set_next[`LCSC_S_SETPOINT]} + {{2{ANALOG_MODULATION_INPUT[15]}}, ANALOG_MODULATION_INPUT};
    if (mod_sum[17]) begin
      cur_next = 16'h0000;
    end else if (mod_sum > {2'b00, set_next[`LCSC_S_LIMIT]}) begin
      cur_next = set_next[`LCSC_S_LIMIT];
    end else begin
      cur_next = mod_sum[15:0];
    end
    if (!on_next) begin
      cur_next = 16'h0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < `LCSC_NSET; i++) begin
        set_reg[i] <= factory_val(i);
      end
      LOCK_STATE <= LK_NONE;
      cp_st_reg <= CP_IDLE;
      cp_cnt_reg <= 4'h0;
      slot_reg <= 2'b00;
      OUT_CURRENT <= 16'h0000;
      OUT_EN <= 1'b0;
      ENABLE_LED <= 1'b0;
      ENABLE_STATUS_N <= 1'b1;
      APP_POWER <= 1'b0;
      INTERVAL_ADVISE <= 1'b0;
    end else begin
      set_reg <= set_next;
      LOCK_STATE <= lock_next;
      cp_st_reg <= cp_st_next;
      cp_cnt_reg <= cp_cnt_next;
      slot_reg <= slot_next;
      OUT_CURRENT <= cur_next;
      OUT_EN <= on_next;
      ENABLE_LED <= on_next;
      ENABLE_STATUS_N <= !on_next;
      APP_POWER <= app_next;
      INTERVAL_ADVISE <= (set_next[`LCSC_S_INTERVAL] < `LCSC_ADVISE_INTERVAL_MS);
    end
  end

  lcsc_prof_mem u_mem (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .we(mem_we),
    .addr({slot_reg, cp_cnt_reg}),
    .wdata(set_reg[cp_cnt_reg]),
    .rdata(mem_rdata)
  );

  // =====================================================
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_enable_delay: assert property ($rose(on_reg) |-> $past(ena_st_reg) == ENA_WAIT &&
    $past(ena_cnt_reg) == 27'(ENA_CYC - 1)) else $error("enable came on without full delay");
  chk_dark_no_current: assert property (!ENABLE_LED |-> OUT_CURRENT == 16'h0000)
    else $error("current flows while indicator dark");
  chk_step_range: assert property (sw_st_reg == SW_IDLE && RUN_REQ && on_reg && cp_st_reg == CP_IDLE &&
    set_reg[`LCSC_S_STEP] > `LCSC_STEP_MAX |=> SWEEP_REJECT && !SWEEP_BUSY) else $error("oversize step accepted");
  chk_interval_min: assert property (sw_st_reg == SW_IDLE && RUN_REQ && on_reg && cp_st_reg == CP_IDLE &&
    set_reg[`LCSC_S_INTERVAL] < `LCSC_MIN_INTERVAL_MS |=> SWEEP_REJECT) else $error("short interval accepted");
  chk_read_le_stop: assert property (sw_st_reg == SW_MEAS |-> level_reg <= set_reg[`LCSC_S_STOP])
    else $error("reading beyond stop current");
  chk_stop_ends: assert property (sw_st_reg == SW_SETTLE && STOP_REQ |=> sw_st_reg == SW_IDLE && RECORD_DONE)
    else $error("stop did not end sweep");
  chk_done_zero: assert property (sw_st_reg == SW_MEAS && level_reg >= set_reg[`LCSC_S_STOP] |=>
    !OUT_EN && set_reg[`LCSC_S_SETPOINT] == 16'h0000 ##1 OUT_CURRENT == 16'h0000) else $error("sweep end not off");
  chk_status_level: assert property (ENABLE_STATUS_N == !OUT_EN)
    else $error("enable status level wrong");
  chk_trig_width: assert property ($fell(TRIGGER) && tg_st_reg == TG_IDLE |->
    $past(tg_cnt_reg) == 19'(`LCSC_TRIG_WIDTH_CYC - 1)) else $error("trigger width wrong");
  chk_key_off: assert property (!KEY_UNLOCKED |=> !OUT_EN)
    else $error("output on with key locked");
  chk_holdoff: assert property ($rose(FRONT_POWER) && hold_cnt_reg != 27'h0 && !app_reg |=> !APP_POWER)
    else $error("power restored inside holdoff");
  chk_knob_lock: assert property (LOCK_STATE != LK_NONE && SET_KNOB_WR && !SET_REMOTE_WR &&
    SET_SEL == `LCSC_S_LIMIT && cp_st_reg == CP_IDLE && !FACTORY_REQ |=>
    $stable(set_reg[`LCSC_S_LIMIT])) else $error("knob changed locked value");

  cov_sweep_done: cover property (sw_st_reg == SW_MEAS ##1 sw_st_reg == SW_IDLE && RECORD_DONE);
  cov_trigger: cover property ($rose(TRIGGER));
  cov_recall: cover property (cp_st_reg == CP_RECALL ##1 cp_st_reg == CP_IDLE);
endmodule // lcsc_top
`default_nettype wire

//--- sim/lcsc_meas_equip.sv
// measurement equipment model: load voltage readback and trigger width meter
`timescale 1ns/1ps
`default_nettype none
module lcsc_meas_equip (
  input wire logic clk,
  input wire logic [15:0] current,
  input wire logic trig,
  output logic [15:0] volt,
  output logic [15:0] trig_width
);
  // volt and trig_width stay unknown until first driven; nothing reads them that early
  logic [15:0] cnt = 16'h0000;
  // ====================================================
  // load readback lags the drive by one cycle, like a real meter
  always @(posedge clk) begin
    volt <= (current >> 2) + 16'h0100;
    if (trig) begin
      cnt <= cnt + 16'h0001;
    end else if (cnt != 16'h0000) begin
      trig_width <= cnt;
      cnt <= 16'h0000;
    end
  end
endmodule // lcsc_meas_equip
`default_nettype wire

//--- sim/tb_laser_current_sweep_control.sv
// self-checking bench for the laser current sweep control block
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0d got %0d", nm, e, g); end end
`define PULSE(s) begin s = 1'b1; @(negedge clk); s = 1'b0; end
`define WAITF(s, n) for (int k = 0; k < (n) && s !== 1'b1; k++) @(negedge clk);
module tb_laser_current_sweep_control;
  import lcsc_pkg::*;
  localparam int MS = 4, ENA = 20, HOLD = 30, TDLY = 10;
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b1, key = 1'b1, en_req = 1'b0, dis_req = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [15:0] sdata = 16'h0000;
  logic knob_wr = 1'b0, rem_wr = 1'b0, lk_l = 1'b0, ul_l = 1'b0, lk_r = 1'b0, lk_pw = 1'b0, ul_r = 1'b0;
  logic signed [15:0] modin = 16'sh0000;
  logic run = 1'b0, stop = 1'b0, save = 1'b0, recall = 1'b0, factory = 1'b0;
  logic [1:0] slot = 2'h0;
  logic [15:0] meas, trig_w, rd_i, rd_v, out_i;
  logic app, out_en, led, stat_n, trig, busy, rej, adv, rvalid, rdone;
  lcsc_lock_t lock;
  logic [6:0] ridx;
  int err_total = 0, checks_done = 0, cyc_n = 0;
  always #12.5 clk = ~clk;
  lcsc_top #(.MS_CYC(MS), .ENA_CYC(ENA), .HOLD_CYC(HOLD), .TRIG_DLY_CYC(TDLY)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .FRONT_POWER(pwr), .KEY_UNLOCKED(key), .ENABLE_REQ(en_req),
    .DISABLE_REQ(dis_req), .SET_SEL(sel), .SET_DATA(sdata), .SET_KNOB_WR(knob_wr), .SET_REMOTE_WR(rem_wr),
    .LOCK_LOCAL_REQ(lk_l), .UNLOCK_LOCAL_REQ(ul_l), .LOCK_REMOTE_REQ(lk_r), .LOCK_REMOTE_PW(lk_pw),
    .UNLOCK_REMOTE_REQ(ul_r), .ANALOG_MODULATION_INPUT(modin), .RUN_REQ(run), .STOP_REQ(stop),
    .PROF_SLOT(slot), .SAVE_REQ(save), .RECALL_REQ(recall), .FACTORY_REQ(factory), .MEAS_VOLTAGE(meas),
    .APP_POWER(app), .OUT_EN(out_en), .OUT_CURRENT(out_i), .ENABLE_LED(led), .ENABLE_STATUS_N(stat_n),
    .TRIGGER(trig), .LOCK_STATE(lock), .SWEEP_BUSY(busy), .SWEEP_REJECT(rej), .INTERVAL_ADVISE(adv),
    .READ_VALID(rvalid), .READ_CURRENT(rd_i), .READ_VOLTAGE(rd_v), .RECORD_DONE(rdone), .RECORD_INDEX(ridx));
  lcsc_meas_equip equip (.clk(clk), .current(out_i), .trig(trig), .volt(meas), .trig_width(trig_w));
  // ====================================================
  // shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // the whole run needs about 4000 cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      $display("timeout");
      print_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic remote, input logic [3:0] s, input logic [15:0] d);
    sel = s;
    sdata = d;
    if (remote) `PULSE(rem_wr) else `PULSE(knob_wr)
    cyc(2);
  endtask
  task automatic en_on();
    `PULSE(en_req)
    `WAITF(out_en, ENA + 6)
    cyc(1);
  endtask
  task automatic rej_case(input logic [3:0] s, input logic [15:0] bad, input logic [15:0] good);
    wr(0, s, bad);
    `PULSE(run)
    `WAITF(rej, 3)
    `CHK("sweep reject", 1'b1, rej)
    `CHK("sweep busy", 1'b0, busy)
    wr(0, s, good);
  endtask
  task automatic one_stop();
    `PULSE(run)
    cyc(2);
    `PULSE(stop)
    `WAITF(rdone, 4)
    cyc(1);
  endtask
  // ====================================================
  // scenarios
  task automatic t_power();
    `CHK("app power", 1'b1, app)
    pwr = 1'b0;
    cyc(3);
    `CHK("app power off", 1'b0, app)
    pwr = 1'b1;
    cyc(3);
    `CHK("app power holdoff", 1'b0, app)
    pwr = 1'b0;
    cyc(HOLD + 5);
    pwr = 1'b1;
    cyc(3);
    `CHK("app power again", 1'b1, app)
    $display("power test done");
  endtask
  task automatic t_enable();
    `PULSE(en_req)
    cyc(ENA - 2);
    `CHK("out_en early", 1'b0, out_en)
    `CHK("led early", 1'b0, led)
    `WAITF(out_en, 6)
    `CHK("out_en", 1'b1, out_en)
    `CHK("led together", 1'b1, led)
    `CHK("status low", 1'b0, stat_n)
    key = 1'b0;
    cyc(3);
    `CHK("out_en key", 1'b0, out_en)
    `CHK("led off", 1'b0, led)
    `CHK("status high", 1'b1, stat_n)
    `PULSE(en_req)
    cyc(ENA + 4);
    `CHK("out_en refused", 1'b0, out_en)
    key = 1'b1;
    en_on();
    $display("enable test done");
  endtask
  task automatic t_mod_lock();
    wr(0, 4'h0, 16'h01f4);
    modin = 16'sh012c;
    cyc(2);
    `CHK("mod sum", 16'h0320, out_i)
    modin = 16'sh7fff;
    cyc(2);
    `CHK("mod clamp", 16'h2710, out_i)
    `CHK("mod enabled", 1'b1, out_en)
    modin = 16'shfd44;
    cyc(2);
    `CHK("mod floor", 16'h0000, out_i)
    wr(0, 4'h1, 16'h07d0);
    modin = 16'sh1388;
    cyc(2);
    `CHK("mod limit", 16'h07d0, out_i)
    modin = 16'sh0000;
    wr(0, 4'h1, 16'h2710);
    `CHK("lock start", LK_NONE, lock)
    `PULSE(lk_l)
    cyc(1);
    `CHK("lock local", LK_LOCAL, lock)
    wr(0, 4'h0, 16'h0384);
    `CHK("knob blocked", 16'h01f4, out_i)
    `PULSE(ul_l)
    lk_pw = 1'b1;
    `PULSE(lk_r)
    cyc(1);
    `CHK("lock pw", LK_PASSWORD, lock)
    `PULSE(ul_l)
    cyc(1);
    `CHK("pw local unlock", LK_PASSWORD, lock)
    wr(0, 4'h1, 16'h0100);
    `CHK("pw knob blocked", 16'h01f4, out_i)
    wr(1, 4'h0, 16'h0258);
    `CHK("remote write", 16'h0258, out_i)
    cyc(TDLY - 5);
    `CHK("trigger wait", 1'b0, trig)
    `WAITF(trig, 8)
    `CHK("trigger", 1'b1, trig)
    cyc(820);
    `CHK("trigger width", 16'(`LCSC_TRIG_WIDTH_CYC), trig_w)
    `PULSE(ul_r)
    cyc(1);
    `CHK("remote unlock", LK_NONE, lock)
    $display("modulation and lock test done");
  endtask
  task automatic t_profile();
    wr(0, 4'h0, 16'h02bc);
    wr(0, 4'h9, 16'h05dc);
    `CHK("advise", 1'b1, adv)
    slot = 2'h1;
    `PULSE(save)
    cyc(12);
    wr(0, 4'h0, 16'h0064);
    wr(0, 4'h9, 16'h07d0);
    `CHK("no advise", 1'b0, adv)
    slot = 2'h2;
    `PULSE(save)
    cyc(12);
    slot = 2'h1;
    `PULSE(recall)
    cyc(13);
    `CHK("recall setpoint", 16'h02bc, out_i)
    `CHK("recall interval", 1'b1, adv)
    `PULSE(factory)
    cyc(3);
    `CHK("factory setpoint", 16'h0000, out_i)
    `CHK("factory interval", 1'b0, adv)
    $display("profile test done");
  endtask
  task automatic t_sweep();
    logic [15:0] lv [5] = '{16'h00fa, 16'h01f4, 16'h02ee, 16'h03e8, 16'h0410};
    int last, gap0;
    wr(0, 4'h6, 16'h00fa);
    wr(0, 4'h7, 16'h0410);
    wr(0, 4'h8, 16'h00fa);
    wr(0, 4'h9, 16'h0064);
    rej_case(4'h8, 16'h0063, 16'h00fa);
    rej_case(4'h8, 16'h03e9, 16'h00fa);
    rej_case(4'h9, 16'h0063, 16'h0064);
    rej_case(4'h6, 16'h0411, 16'h00fa);
    `PULSE(run)
    `WAITF(busy, 3)
    `CHK("sweep busy", 1'b1, busy)
    for (int i = 0; i < 5; i++) begin
      `WAITF(rvalid, 600)
      `CHK("read current", lv[i], rd_i)
      `CHK("read voltage", (lv[i] >> 2) + 16'h0100, rd_v)
      if (i == 1) gap0 = cyc_n - last;
      if (i > 1) `CHK("step gap", gap0, cyc_n - last)
      last = cyc_n;
      if (i < 4) @(negedge clk);
    end
    `CHK("settle length", 1'b1, gap0 >= MS * 100)
    `WAITF(rdone, 3)
    `CHK("record done", 1'b1, rdone)
    cyc(2);
    `CHK("sweep end", 1'b0, busy)
    `CHK("end disabled", 1'b0, out_en)
    `CHK("record index", 7'h01, ridx)
    $display("sweep test done");
  endtask
  task automatic t_stop();
    en_on();
    `CHK("setpoint zeroed", 16'h0000, out_i)
    wr(0, 4'h8, 16'h0064);
    wr(0, 4'h7, 16'h2710);
    `PULSE(run)
    `WAITF(rvalid, 600)
    `CHK("min step busy", 1'b1, busy)
    `PULSE(stop)
    `WAITF(rdone, 3)
    `CHK("stop record", 1'b1, rdone)
    cyc(1);
    `CHK("stop idle", 1'b0, busy)
    `CHK("stop enabled", 1'b1, out_en)
    `CHK("kept reading", 16'h00fa, rd_i)
    `CHK("stop index", 7'h02, ridx)
    repeat (97) one_stop();
    `CHK("index 99", 7'h63, ridx)
    one_stop();
    `CHK("index wrap", 7'h00, ridx)
    `PULSE(dis_req)
    cyc(1);
    `CHK("disable led", 1'b0, led)
    `CHK("disable current", 16'h0000, out_i)
    $display("stop test done");
  endtask
  initial begin
    cyc(12);
    `CHK("reset status", 1'b1, stat_n)
    `CHK("reset out_en", 1'b0, out_en)
    `CHK("reset lock", LK_NONE, lock)
    `CHK("reset index", 7'h00, ridx)
    rst_n = 1'b1;
    cyc(2);
    t_power();
    t_enable();
    t_mod_lock();
    t_profile();
    t_sweep();
    t_stop();
    print_verdict();
  end
endmodule // tb_laser_current_sweep_control
`default_nettype wire
